// ### bridge_cfg_pkg.sv
// Constants, types and code tables for the configuration and port
// selection command handler.
// Assumes a byte-level serial front end that delivers received bytes.
package bridge_cfg_pkg;

    // Command codes.
    localparam logic [7:0] CMD_DEVICE_RESET = 8'hF0;
    localparam logic [7:0] CMD_SET_POINTER  = 8'hE1;
    localparam logic [7:0] CMD_WRITE_CONFIG = 8'hD2;
    localparam logic [7:0] CMD_PORT_SELECT  = 8'hC3;

    // Pointer codes.
    localparam logic [7:0] PTR_CODE_STATUS  = 8'hF0;
    localparam logic [7:0] PTR_CODE_DATA    = 8'hE1;
    localparam logic [7:0] PTR_CODE_PORT    = 8'hD2;
    localparam logic [7:0] PTR_CODE_CONFIG  = 8'hC3;

    // Configuration byte layout: low nibble holds the settings.
    localparam int CFG_ACTIVE_PULLUP_BIT   = 0;
    localparam int CFG_PRESENCE_MASK_BIT   = 1;
    localparam int CFG_STRONG_PULLUP_BIT   = 2;
    localparam int CFG_SPEED_SELECT_BIT    = 3;
    localparam logic [3:0] CFG_READ_UPPER  = 4'h0;
    localparam logic [3:0] CFG_RESET_VALUE = 4'h0;
    localparam logic [2:0] PORT_RESET_VALUE = 3'h0;
    localparam int NUM_PORTS = 8;

    // Port selection codes, index is the port number.
    localparam logic [7:0] SEL_WRITE_CODE [NUM_PORTS] = '{
        8'hF0, 8'hE1, 8'hD2, 8'hC3, 8'hB4, 8'hA5, 8'h96, 8'h87};
    localparam logic [7:0] SEL_READ_CODE [NUM_PORTS] = '{
        8'hB8, 8'hB1, 8'hAA, 8'hA3, 8'h9C, 8'h95, 8'h8E, 8'h87};

    // Line feature settings.
    typedef struct packed {
        logic speed_select;
        logic strong_pullup_enable;
        logic presence_mask_enable;
        logic active_pullup_enable;
    } line_cfg_t;

    // Read pointer targets.
    typedef enum logic [1:0] {
        PTR_STATUS = 2'h0,
        PTR_DATA   = 2'h1,
        PTR_PORT   = 2'h2,
        PTR_CONFIG = 2'h3
    } read_ptr_t;

    // Command sequencer states, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_PARAM   = 4'b0010,
        ST_ACKWAIT = 4'b0100,
        ST_IGNORE  = 4'b1000
    } cmd_state_t;

endpackage : bridge_cfg_pkg

// ### bridge_cfg_channel_select.sv
// Command handler for configuration writes, port selection, read
// pointer setting and global device reset.
// Assumes a serial front end on ref_clk_in that pulses byte_valid_in
// once per received byte and drives the acknowledge bit from ack_out;
// the bus clock pin arrives unsynchronised on scl_in.
`timescale 1ns/1ns

// Function
// (RL1) Config write code D2h, one parameter byte.
// (RL2) Accept config only with complemented upper nibble.
// (RL3) Config read back has zero upper nibble.
// (RL4) Config loads at acknowledge rising edge.
// (RL5) Busy line refuses config and select commands.
// (RL6) Config write points reader at config register.
// (RL7) Config write updates exactly four settings.
// (RL8) Select code C3h picks one of eight ports.
// (RL9) Write codes F0h through 87h map ports.
// (RL10) Read back codes B8h through 87h per port.
// (RL11) Invalid selection code is refused, unchanged.
// (RL12) Selection loads at acknowledge rising edge.
// (RL13) Port select points reader at selection register.
// (RL14) Accepted config write clears reset indicator.
// (RL15) Global reset selects port zero, clears config.
// (RL16) Pointer codes C3h config, D2h selection.
// (RL17) Host polls busy flag before these commands.
module bridge_cfg_channel_select (
    input  wire logic                       ref_clk_in,
    input  wire logic                       reset_n_in,
    input  wire logic                       clk_en_in,
    input  wire logic                       scl_in,
    input  wire logic                       frame_start_in,
    input  wire logic                       byte_valid_in,
    input  wire logic [7:0]                 byte_in,
    input  wire logic                       line_busy_flag_in,
    input  wire logic [7:0]                 status_byte_in,
    input  wire logic [7:0]                 data_byte_in,
    output logic                            ack_out,
    output bridge_cfg_pkg::line_cfg_t       line_cfg_out,
    output logic [2:0]                      active_port_out,
    output bridge_cfg_pkg::read_ptr_t       read_ptr_out,
    output logic [7:0]                      read_byte_out,
    output logic                            reset_flag_out,
    output logic                            line_reset_out
);
    import bridge_cfg_pkg::*;

    logic        scl_meta_q;
    logic        scl_sync_q;
    logic        scl_prev_q;
    logic        scl_rise;
    cmd_state_t  state_q;
    cmd_state_t  state_d;
    logic [7:0]  cmd_q;
    logic [7:0]  cmd_d;
    logic [7:0]  param_q;
    logic [7:0]  param_d;
    logic        ack_q;
    logic        ack_d;
    line_cfg_t   cfg_q;
    line_cfg_t   cfg_d;
    logic [2:0]  port_q;
    logic [2:0]  port_d;
    read_ptr_t   ptr_q;
    read_ptr_t   ptr_d;
    logic        rst_flag_q;
    logic        rst_flag_d;
    logic        line_reset_q;
    logic        line_reset_d;
    logic [7:0]  read_byte_q;
    logic [7:0]  read_byte_d;
    logic [7:0]  sel_match;
    logic        sel_valid;
    logic [2:0]  sel_port;
    logic        cfg_valid;
    logic        ptr_valid;
    read_ptr_t   ptr_decoded;

    // Bus clock pin synchroniser; only the second and third stages feed logic.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            scl_meta_q <= 1'b0;
            scl_sync_q <= 1'b0;
            scl_prev_q <= 1'b0;
        end else if (clk_en_in) begin
            scl_meta_q <= scl_in;
            scl_sync_q <= scl_meta_q;
            scl_prev_q <= scl_sync_q;
        end
    end

    assign scl_rise = scl_sync_q & ~scl_prev_q;

    // Per-entry compare of the parameter against the selection codes.
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_sel
        assign sel_match[i] = (byte_in == SEL_WRITE_CODE[i]); // RL9
    end

    // Encodes the matching port; at most one code can match.
    always_comb begin
        sel_port = 3'h0;
        for (int j = 0; j < NUM_PORTS; j++) begin
            if (sel_match[j]) begin
                sel_port = j[2:0];
            end
        end
    end

    assign sel_valid = |sel_match;
    assign cfg_valid = (byte_in[7:4] == ~byte_in[3:0]); // RL2

    // Decodes a pointer code into its register target.
    always_comb begin
        ptr_valid   = 1'b1;
        ptr_decoded = PTR_STATUS;
        case (byte_in)
            PTR_CODE_STATUS: ptr_decoded = PTR_STATUS;
            PTR_CODE_DATA:   ptr_decoded = PTR_DATA;
            PTR_CODE_PORT:   ptr_decoded = PTR_PORT;   // RL16
            PTR_CODE_CONFIG: ptr_decoded = PTR_CONFIG; // RL16
            default:         ptr_valid   = 1'b0;
        endcase
    end

    // Command sequencer: decides the acknowledge for each byte and
    // commits the pending update on the acknowledge bit rising edge.
    always_comb begin
        state_d      = state_q;
        cmd_d        = cmd_q;
        param_d      = param_q;
        ack_d        = ack_q;
        cfg_d        = cfg_q;
        port_d       = port_q;
        ptr_d        = ptr_q;
        rst_flag_d   = rst_flag_q;
        line_reset_d = 1'b0;
        if (frame_start_in) begin
            state_d = ST_IDLE;
            ack_d   = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (byte_valid_in) begin
                        cmd_d = byte_in;
                        case (byte_in)
                            CMD_WRITE_CONFIG,
                            CMD_PORT_SELECT: begin // RL1 RL8
                                if (line_busy_flag_in) begin // RL5
                                    ack_d   = 1'b0;
                                    state_d = ST_IGNORE;
                                end else begin
                                    ack_d   = 1'b1;
                                    state_d = ST_PARAM;
                                end
                            end
                            CMD_SET_POINTER: begin
                                ack_d   = 1'b1;
                                state_d = ST_PARAM;
                            end
                            CMD_DEVICE_RESET: begin
                                ack_d   = 1'b1;
                                state_d = ST_ACKWAIT;
                            end
                            default: begin
                                ack_d   = 1'b0;
                                state_d = ST_IGNORE;
                            end
                        endcase
                    end
                end
                ST_PARAM: begin
                    if (byte_valid_in) begin
                        param_d = byte_in;
                        if ((cmd_q == CMD_WRITE_CONFIG && cfg_valid) ||
                            (cmd_q == CMD_PORT_SELECT && sel_valid) ||
                            (cmd_q == CMD_SET_POINTER && ptr_valid)) begin
                            ack_d   = 1'b1;
                            state_d = ST_ACKWAIT;
                        end else begin
                            ack_d   = 1'b0; // RL2 RL11
                            state_d = ST_IGNORE;
                        end
                        if (cmd_q == CMD_PORT_SELECT) begin
                            param_d = {5'h00, sel_port};
                        end else if (cmd_q == CMD_SET_POINTER) begin
                            param_d = {6'h00, ptr_decoded};
                        end
                    end
                end
                ST_ACKWAIT: begin
                    if (scl_rise) begin
                        state_d = ST_IDLE;
                        case (cmd_q)
                            CMD_WRITE_CONFIG: begin
                                cfg_d      = param_q[3:0]; // RL4 RL7
                                ptr_d      = PTR_CONFIG;   // RL6
                                rst_flag_d = 1'b0;         // RL14
                            end
                            CMD_PORT_SELECT: begin
                                port_d = param_q[2:0]; // RL12
                                ptr_d  = PTR_PORT;     // RL13
                            end
                            CMD_SET_POINTER: begin
                                ptr_d = read_ptr_t'(param_q[1:0]);
                            end
                            default: begin
                                cfg_d        = CFG_RESET_VALUE;  // RL15
                                port_d       = PORT_RESET_VALUE; // RL15
                                ptr_d        = PTR_STATUS;
                                rst_flag_d   = 1'b1;
                                line_reset_d = 1'b1;
                            end
                        endcase
                    end
                end
                ST_IGNORE: begin
                    if (byte_valid_in) begin
                        ack_d = 1'b0; // RL5
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    // Read data multiplexer at the read pointer.
    always_comb begin
        case (ptr_q)
            PTR_CONFIG: read_byte_d = {CFG_READ_UPPER, cfg_q}; // RL3
            PTR_PORT:   read_byte_d = SEL_READ_CODE[port_q];  // RL10
            PTR_DATA:   read_byte_d = data_byte_in;
            default:    read_byte_d = status_byte_in;
        endcase
    end

    // Register stage for the sequencer and the visible settings.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q      <= ST_IDLE;
            cmd_q        <= 8'h00;
            param_q      <= 8'h00;
            ack_q        <= 1'b0;
            cfg_q        <= CFG_RESET_VALUE;
            port_q       <= PORT_RESET_VALUE;
            ptr_q        <= PTR_STATUS;
            rst_flag_q   <= 1'b1;
            line_reset_q <= 1'b0;
            read_byte_q  <= 8'h00;
        end else if (clk_en_in) begin
            state_q      <= state_d;
            cmd_q        <= cmd_d;
            param_q      <= param_d;
            ack_q        <= ack_d;
            cfg_q        <= cfg_d;
            port_q       <= port_d;
            ptr_q        <= ptr_d;
            rst_flag_q   <= rst_flag_d;
            line_reset_q <= line_reset_d;
            read_byte_q  <= read_byte_d;
        end
    end

    assign ack_out         = ack_q;
    assign line_cfg_out    = cfg_q;
    assign active_port_out = port_q;
    assign read_ptr_out    = ptr_q;
    assign read_byte_out   = read_byte_q;
    assign reset_flag_out  = rst_flag_q;
    assign line_reset_out  = line_reset_q;

endmodule : bridge_cfg_channel_select

// ### host_link_model.sv
// Host side model: start marks, received bytes and the ack bit clock.
// Assumes the bench calls its tasks and wires ack_in to the handler.
`timescale 1ns/1ns
module host_link_model (
    input  wire logic       ref_clk_in,
    input  wire logic       ack_in,
    output logic            frame_start_out,
    output logic            byte_valid_out,
    output logic [7:0]      byte_out,
    output logic            scl_out
);
    // Idle levels; the bus clock stands low outside transfers.
    initial begin
        frame_start_out = 1'b0;
        byte_valid_out  = 1'b0;
        byte_out        = 8'h00;
        scl_out         = 1'b0;
    end

    // Marks a start condition for one clock.
    task automatic start_frame();
        @(posedge ref_clk_in) frame_start_out <= 1'b1;
        @(posedge ref_clk_in) frame_start_out <= 1'b0;
    endtask : start_frame

    // Sends one byte, takes its acknowledge, then clocks the ack bit.
    task automatic send_byte(input logic [7:0] b, output logic ack);
        @(posedge ref_clk_in) begin
            byte_valid_out <= 1'b1;
            byte_out       <= b;
        end
        @(posedge ref_clk_in) begin
            byte_valid_out <= 1'b0;
            byte_out       <= ~b; // Stale data never lingers.
        end
        @(posedge ref_clk_in) ack = ack_in;
        scl_out <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        scl_out <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
    endtask : send_byte
endmodule : host_link_model

// ### bridge_cfg_channel_select_properties.sv
// Port level checks of the configuration and port select handler.
// Assumes it is bound into every handler instance.
`timescale 1ns/1ns
module bridge_cfg_channel_select_properties import bridge_cfg_pkg::*; (
    input wire logic                      ref_clk_in,
    input wire logic                      reset_n_in,
    input wire logic                      clk_en_in,
    input wire logic                      scl_in,
    input wire logic                      frame_start_in,
    input wire logic                      byte_valid_in,
    input wire logic [7:0]                byte_in,
    input wire logic                      line_busy_flag_in,
    input wire logic [7:0]                status_byte_in,
    input wire logic [7:0]                data_byte_in,
    input wire logic                      ack_out,
    input wire bridge_cfg_pkg::line_cfg_t line_cfg_out,
    input wire logic [2:0]                active_port_out,
    input wire bridge_cfg_pkg::read_ptr_t read_ptr_out,
    input wire logic [7:0]                read_byte_out,
    input wire logic                      reset_flag_out,
    input wire logic                      line_reset_out
);
    // All checks share the system clock and the asynchronous reset.
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_ack_stands;
        !byte_valid_in && !frame_start_in |=> $stable(ack_out);
    endproperty
    a_ack_stands: assert property (p_ack_stands)
        else $error("acknowledge moved without a byte");
    property p_busy_refuse;
        frame_start_in ##2 (byte_valid_in && line_busy_flag_in &&
            (byte_in == 8'hD2 || byte_in == 8'hC3)) |=> (!ack_out)[*8];
    endproperty
    a_busy_refuse: assert property (p_busy_refuse)
        else $error("busy command acknowledged");
    property p_cfg_read;
        (read_ptr_out == PTR_CONFIG)[*2] |->
            read_byte_out == {4'h0, $past(line_cfg_out)};
    endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("config read back wrong");
    property p_port_read;
        (read_ptr_out == PTR_PORT)[*2] |->
            read_byte_out == SEL_READ_CODE[$past(active_port_out)];
    endproperty
    a_port_read: assert property (p_port_read)
        else $error("port read back wrong");
    property p_cfg_commit;
        !$stable(line_cfg_out) |-> $past(scl_in, 2) && $past(ack_out);
    endproperty
    a_cfg_commit: assert property (p_cfg_commit)
        else $error("config changed off the ack clock");
    property p_port_commit;
        !$stable(active_port_out) |-> $past(scl_in, 2) && $past(ack_out);
    endproperty
    a_port_commit: assert property (p_port_commit)
        else $error("port changed off the ack clock");
    property p_flag_clear;
        $fell(reset_flag_out) |-> read_ptr_out == PTR_CONFIG;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("reset flag cleared outside config write");
    property p_sel_ptr;
        !$stable(active_port_out) |-> read_ptr_out == PTR_PORT ||
            read_ptr_out == PTR_STATUS;
    endproperty
    a_sel_ptr: assert property (p_sel_ptr)
        else $error("pointer not moved by port select");
    property p_line_reset;
        line_reset_out |=> !line_reset_out && active_port_out == 3'h0 &&
            line_cfg_out == 4'h0 && reset_flag_out;
    endproperty
    a_line_reset: assert property (p_line_reset)
        else $error("device reset left state behind");

    // Main scenarios reached.
    c_reset: cover property (line_reset_out);
    c_flag: cover property ($fell(reset_flag_out));
    c_busy: cover property (byte_valid_in && line_busy_flag_in);
endmodule : bridge_cfg_channel_select_properties

bind bridge_cfg_channel_select bridge_cfg_channel_select_properties
    u_props (.*);

// ### bridge_cfg_channel_select_tb.sv
// Self-checking bench for the configuration and port select handler.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ns
`define CHK(a, e) check_vals((a), (e))
module bridge_cfg_channel_select_tb;
    import bridge_cfg_pkg::*;
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] prm;
        logic       ack;
        logic [7:0] rd;
    } row_t;
    logic       ref_clk_in, reset_n_in, busy, scl, fs, bv, ack, a1, a2;
    logic       lrst, rflag;
    logic [7:0] bt, rd;
    logic [2:0] port;
    line_cfg_t  cfg;
    read_ptr_t  ptr;
    int         err_count = 0, check_count = 0, cycles = 0;
    row_t       rows [17] = '{
        '{8'hC3, 8'hF0, 1'b1, 8'hB8}, '{8'hC3, 8'hE1, 1'b1, 8'hB1},
        '{8'hC3, 8'hD2, 1'b1, 8'hAA}, '{8'hC3, 8'hC3, 1'b1, 8'hA3},
        '{8'hC3, 8'hB4, 1'b1, 8'h9C}, '{8'hC3, 8'hA5, 1'b1, 8'h95},
        '{8'hC3, 8'h96, 1'b1, 8'h8E}, '{8'hC3, 8'h87, 1'b1, 8'h87},
        '{8'hC3, 8'h55, 1'b0, 8'h87}, '{8'hD2, 8'hE1, 1'b1, 8'h01},
        '{8'hD2, 8'h5B, 1'b0, 8'h01}, '{8'hD2, 8'h0F, 1'b1, 8'h0F},
        '{8'hE1, 8'hD2, 1'b1, 8'h87}, '{8'hE1, 8'hC3, 1'b1, 8'h0F},
        '{8'hE1, 8'hE1, 1'b1, 8'h3E}, '{8'hE1, 8'hF0, 1'b1, 8'h5C},
        '{8'hD2, 8'hF0, 1'b1, 8'h00}};

    // System clock of 20 ns.
    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    host_link_model host (.ref_clk_in(ref_clk_in), .ack_in(ack),
        .frame_start_out(fs), .byte_valid_out(bv), .byte_out(bt),
        .scl_out(scl));
    bridge_cfg_channel_select dut (.ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in), .clk_en_in(1'b1), .scl_in(scl),
        .frame_start_in(fs), .byte_valid_in(bv), .byte_in(bt),
        .line_busy_flag_in(busy), .status_byte_in(8'h5C),
        .data_byte_in(8'h3E), .ack_out(ack), .line_cfg_out(cfg),
        .active_port_out(port), .read_ptr_out(ptr), .read_byte_out(rd),
        .reset_flag_out(rflag), .line_reset_out(lrst));

    // Counts and reports one comparison.
    task automatic check_vals(input logic [8:0] got, input logic [8:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_vals

    // Prints the verdict and ends the run.
    task automatic stop_test();
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // One framed command with its parameter byte.
    task automatic run_cmd(input logic [7:0] c, input logic [7:0] p,
                           output logic ac, output logic ap);
        host.start_frame();
        host.send_byte(c, ac);
        host.send_byte(p, ap);
    endtask : run_cmd

    // Cuts a hang short.
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            stop_test();
        end
    end

    // Reset, table of ordinary commands, then refusals and device reset.
    initial begin
        reset_n_in = 1'b0;
        busy = 1'b0;
        repeat (6) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        `CHK({rflag, cfg, port}, 8'h80);
        `CHK(rd, 8'h5C);
        foreach (rows[i]) begin
            run_cmd(rows[i].cmd, rows[i].prm, a1, a2);
            `CHK(a1, 1'b1);
            `CHK(a2, rows[i].ack);
            `CHK(rd, rows[i].rd);
        end
        `CHK({rflag, port}, 4'h7);
        busy <= 1'b1;
        run_cmd(CMD_WRITE_CONFIG, 8'hE1, a1, a2);
        `CHK({a1, a2, cfg}, 6'h00);
        run_cmd(CMD_PORT_SELECT, 8'hB4, a1, a2);
        `CHK({a1, a2, port}, 5'h07);
        busy <= 1'b0;
        run_cmd(CMD_WRITE_CONFIG, 8'h1E, a1, a2);
        `CHK({a2, cfg}, 5'h1E);
        `CHK(ptr, PTR_CONFIG);
        host.start_frame();
        host.send_byte(8'hF0, a1);
        `CHK({a1, rflag, cfg, port}, 9'h180);
        `CHK(rd, 8'h5C);
        stop_test();
    end
endmodule : bridge_cfg_channel_select_tb
